//--- src/lcfec_defs.svh
`ifndef LCFEC_DEFS_SVH
`define LCFEC_DEFS_SVH
// timing, ramp and level constants
`define LCFEC_CLK_HZ        40000000
`define LCFEC_PWM_HZ        220
`define LCFEC_PWM_PERIOD    (`LCFEC_CLK_HZ / `LCFEC_PWM_HZ)
`define LCFEC_DEBOUNCE_US   10
`define LCFEC_DEBOUNCE_CYC  ((`LCFEC_CLK_HZ / 1000000) * `LCFEC_DEBOUNCE_US)
`define LCFEC_DEGLITCH_US   2
`define LCFEC_DEGLITCH_CYC  ((`LCFEC_CLK_HZ / 1000000) * `LCFEC_DEGLITCH_US)
`define LCFEC_STEPS         63
`define LCFEC_STEP_DEF      2000
`define LCFEC_LEVEL_MAX     8'hff
`endif

//--- src/lcfec_pkg.sv
package lcfec_pkg;
  typedef enum logic [1:0] {
    LCFEC_IDLE = 2'b00,
    LCFEC_UP   = 2'b01,
    LCFEC_DOWN = 2'b10
  } lcfec_ramp_t;

  // per-channel state
  typedef struct packed {
    logic [1:0]  sync;
    logic        stable;
    logic [15:0] dcnt;
    logic        on;
    lcfec_ramp_t ramp;
    logic [5:0]  step;
    logic [31:0] tcnt;
  } lcfec_chan_t;

  // fault inputs grouped
  typedef struct packed {
    logic short_f;
    logic open_f;
    logic therm_f;
  } lcfec_fault_t;
endpackage

//--- src/lcfec_top.sv
`timescale 1ns/1ps
`include "lcfec_defs.svh"
module lcfec_top #(
  parameter int unsigned STEP_UP_DEF = `LCFEC_STEP_DEF,
  parameter int unsigned DEBOUNCE    = `LCFEC_DEBOUNCE_CYC,
  parameter int unsigned PWM_PERIOD  = `LCFEC_PWM_PERIOD
) (
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  input  wire logic                main_enable_a,
  input  wire logic                main_enable_b,
  input  wire logic                backlight_enable,
  input  wire logic                pulse_mode,
  input  wire logic                int_pwm_mode,
  input  wire logic [1:0]          cmd_valid,
  input  wire logic [1:0]          cmd_on,
  input  wire logic [31:0]         fade_up_time_set,
  input  wire logic [31:0]         fade_down_time_set,
  input  wire lcfec_pkg::lcfec_fault_t fault_in,
  output logic [7:0]               main_output_a,
  output logic [7:0]               main_output_b,
  output logic                     main_pwm_a,
  output logic                     main_pwm_b,
  output logic                     backlight_output,
  output logic                     fault_flag_n_o,
  output logic                     fault_flag_n_oe,
  output logic [1:0]               chan_on_state,
  output lcfec_pkg::lcfec_fault_t  fault_flags
);
  // ==========================================
  // state
  typedef struct packed {
    lcfec_pkg::lcfec_chan_t [1:0] ch;
    logic [1:0]              bsync;
    logic [15:0]             bcnt;
    logic                    bl;
    logic [2:0][1:0]         fsync;
    lcfec_pkg::lcfec_fault_t flt;
    logic                    pwm_run;
    logic [31:0]             pcnt;
    logic [1:0][7:0]         lvl;
    logic [1:0]              pwm;
    logic [1:0]              ovr;
  } lcfec_state_t;

  lcfec_state_t s_q;
  lcfec_state_t s_d;

  // gamma curve: roughly quadratic over 63 steps
  function automatic logic [7:0] gamma(input logic [5:0] st);
    logic [11:0] sq;
    sq = 12'(st) * 12'(st);
    gamma = (st >= 6'(`LCFEC_STEPS)) ? `LCFEC_LEVEL_MAX : 8'(sq >> 4);
  endfunction

  logic [1:0] pins;
  assign pins = {main_enable_b, main_enable_a};

  // ==========================================
  // next state
  always_comb
  begin
    logic       trig;
    logic       want;
    logic [31:0] tset;
    s_d = s_q;
    trig = 1'b0;
    want = 1'b0;
    tset = 32'h0;
    for (int i = 0; i < 2; i++)
    begin
      s_d.ch[i].sync = {s_q.ch[i].sync[0], pins[i]};
      // debounce: level must hold DEBOUNCE cycles
      if (s_q.ch[i].sync[1] == s_q.ch[i].stable)
        s_d.ch[i].dcnt = 16'h0;
      else if (32'(s_q.ch[i].dcnt) >= DEBOUNCE - 1)
      begin
        s_d.ch[i].dcnt = 16'h0;
        s_d.ch[i].stable = s_q.ch[i].sync[1];
      end
      else
        s_d.ch[i].dcnt = s_q.ch[i].dcnt + 16'h1;
      trig = 1'b0;
      want = s_q.ch[i].on;
      // in level mode a command holds until the debounced pin level next moves
      if (cmd_valid[i])
        s_d.ovr[i] = 1'b1;
      else if (pulse_mode || (s_d.ch[i].stable != s_q.ch[i].stable))
        s_d.ovr[i] = 1'b0;
      if (cmd_valid[i])
      begin
        want = cmd_on[i];
        trig = (cmd_on[i] != s_q.ch[i].on);
      end
      else if (pulse_mode)
      begin
        // toggle on the qualified falling edge only
        if (s_q.ch[i].stable && !s_d.ch[i].stable)
        begin
          want = !s_q.ch[i].on;
          trig = 1'b1;
        end
      end
      else if (!s_q.ovr[i] && (s_q.ch[i].stable != s_q.ch[i].on))
      begin
        want = s_q.ch[i].stable;
        trig = 1'b1;
      end
      if (trig)
      begin
        s_d.ch[i].on = want;
        s_d.ch[i].tcnt = 32'h0;
        if (want)
        begin
          if (fade_up_time_set == 32'h0)
          begin
            s_d.ch[i].step = 6'(`LCFEC_STEPS);
            s_d.ch[i].ramp = lcfec_pkg::LCFEC_IDLE;
          end
          else
            s_d.ch[i].ramp = lcfec_pkg::LCFEC_UP;
        end
        else if (fade_down_time_set == 32'h0)
        begin
          s_d.ch[i].step = 6'h0;
          s_d.ch[i].ramp = lcfec_pkg::LCFEC_IDLE;
        end
        else
          s_d.ch[i].ramp = lcfec_pkg::LCFEC_DOWN;
      end
      else
      begin
        // step timer, separate up and down durations
        tset = (s_q.ch[i].ramp == lcfec_pkg::LCFEC_UP) ? fade_up_time_set : fade_down_time_set;
        case (s_q.ch[i].ramp)
          lcfec_pkg::LCFEC_UP, lcfec_pkg::LCFEC_DOWN:
          begin
            if (s_q.ch[i].tcnt + 32'h1 >= tset)
            begin
              s_d.ch[i].tcnt = 32'h0;
              // saturate at both ends so a reversal never wraps the step
              if (s_q.ch[i].ramp == lcfec_pkg::LCFEC_UP)
              begin
                if (s_q.ch[i].step < 6'(`LCFEC_STEPS))
                  s_d.ch[i].step = s_q.ch[i].step + 6'h1;
                if (s_q.ch[i].step >= 6'(`LCFEC_STEPS - 1))
                  s_d.ch[i].ramp = lcfec_pkg::LCFEC_IDLE;
              end
              else
              begin
                if (s_q.ch[i].step != 6'h0)
                  s_d.ch[i].step = s_q.ch[i].step - 6'h1;
                if (s_q.ch[i].step <= 6'h1)
                  s_d.ch[i].ramp = lcfec_pkg::LCFEC_IDLE;
              end
            end
            else
              s_d.ch[i].tcnt = s_q.ch[i].tcnt + 32'h1;
          end
          default:
            s_d.ch[i].tcnt = 32'h0;
        endcase
      end
      s_d.lvl[i] = gamma(s_q.ch[i].step);
    end
    // internal pwm runs once a command arrives in that mode
    if (!int_pwm_mode)
      s_d.pwm_run = 1'b0;
    else if (|cmd_valid)
      s_d.pwm_run = 1'b1;
    s_d.pcnt = (s_q.pcnt + 32'h1 >= PWM_PERIOD) ? 32'h0 : s_q.pcnt + 32'h1;
    for (int i = 0; i < 2; i++)
      s_d.pwm[i] = s_q.pwm_run ? (s_q.pcnt[31:0] < ((PWM_PERIOD * 32'(s_q.lvl[i])) >> 8)) : 1'b0;
    // backlight deglitch
    s_d.bsync = {s_q.bsync[0], backlight_enable};
    if (s_q.bsync[1] == s_q.bl)
      s_d.bcnt = 16'h0;
    else if (s_q.bcnt >= 16'(`LCFEC_DEGLITCH_CYC - 1))
    begin
      s_d.bcnt = 16'h0;
      s_d.bl = s_q.bsync[1];
    end
    else
      s_d.bcnt = s_q.bcnt + 16'h1;
    // fault sync and flags
    s_d.fsync[0] = {s_q.fsync[0][0], fault_in.short_f};
    s_d.fsync[1] = {s_q.fsync[1][0], fault_in.open_f};
    s_d.fsync[2] = {s_q.fsync[2][0], fault_in.therm_f};
    s_d.flt.short_f = s_q.fsync[0][1];
    s_d.flt.open_f  = s_q.fsync[1][1];
    s_d.flt.therm_f = s_q.fsync[2][1];
  end

  // ==========================================
  // registers
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // outputs straight from flops, except fault_flag_n_o tied low and fault_flag_n_oe decoded from the flags
  assign main_output_a    = s_q.lvl[0];
  assign main_output_b    = s_q.lvl[1];
  assign main_pwm_a       = s_q.pwm[0];
  assign main_pwm_b       = s_q.pwm[1];
  assign backlight_output = s_q.bl;
  assign chan_on_state    = {s_q.ch[1].on, s_q.ch[0].on};
  assign fault_flags      = s_q.flt;
  assign fault_flag_n_o   = 1'b0;
  assign fault_flag_n_oe  = !(|s_q.flt); // low enable = drive low

  // ==========================================
  // checks
  // any fault seen at the pins pulls the flag within the sync delay
  fault_pin_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (|fault_in) |-> ##3 !fault_flag_n_oe) else $error("fault pin not driven");
  fault_rel_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!(|fault_in))[*5] |-> fault_flag_n_oe) else $error("fault pin stuck");
  cmd_over_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cmd_valid[0] |=> s_q.ch[0].on == $past(cmd_on[0])) else $error("command ignored");
  inst_on_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cmd_valid[0] && cmd_on[0] && !s_q.ch[0].on && fade_up_time_set == 32'h0)
    |=> s_q.ch[0].step == 6'd63) else $error("instant on failed");
  inst_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cmd_valid[0] && !cmd_on[0] && s_q.ch[0].on && fade_down_time_set == 32'h0)
    |=> s_q.ch[0].step == 6'd0) else $error("instant off failed");
  up_ramp_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (s_q.ch[0].ramp == lcfec_pkg::LCFEC_UP) |-> s_q.ch[0].on) else $error("ramp up while off");
  down_ramp_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (s_q.ch[0].ramp == lcfec_pkg::LCFEC_DOWN) |-> !s_q.ch[0].on) else $error("ramp down while on");
  pwm_idle_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !s_q.pwm_run |=> !main_pwm_a) else $error("pwm without command");
  lvl_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!pulse_mode && !cmd_valid[0] && !s_q.ovr[0] && (s_q.ch[0].stable != s_q.ch[0].on))
    |=> s_q.ch[0].on == $past(s_q.ch[0].stable)) else $error("level mode mismatch");
  up_cov: cover property (@(posedge ref_clk) s_q.ch[0].ramp == lcfec_pkg::LCFEC_UP ##1
    s_q.ch[0].ramp == lcfec_pkg::LCFEC_DOWN);
  bl_cov: cover property (@(posedge ref_clk) $rose(backlight_output));
  flt_cov: cover property (@(posedge ref_clk) $fell(fault_flag_n_oe));
endmodule

//--- testbench/lcfec_switch_model.sv
`timescale 1ns/1ps
// ==========================================
// panel switch pair with the pin pull per mode
module lcfec_switch_model (
  input  wire logic       pulse_mode,
  input  wire logic [1:0] press,
  output logic      [1:0] pin
);
  // pressed drives the active level, released falls to the pull
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      pin[i] = press[i] ? !pulse_mode : pulse_mode;
    end
  end
endmodule

//--- testbench/lcfec_top_tb.sv
`timescale 1ns/1ps
// ==========================================
// bench for the channel control block
module lcfec_top_tb;
  logic                   ref_clk = 1'b0;
  logic                   reset_n = 1'b0;
  logic                   bl      = 1'b0;
  logic                   pm      = 1'b1;
  logic                   ipm     = 1'b0;
  logic [1:0]             cv      = 2'h0;
  logic [1:0]             con     = 2'h0;
  logic [1:0]             press   = 2'h0;
  logic [1:0]             pins;
  logic [31:0]            fup     = 32'h0;
  logic [31:0]            fdn     = 32'h0;
  lcfec_pkg::lcfec_fault_t flt    = '0;
  lcfec_pkg::lcfec_fault_t fflags;
  logic [7:0]             out_a;
  logic [7:0]             out_b;
  logic [7:0]             v;
  logic                   pwm_a;
  logic                   pwm_b;
  logic                   bl_o;
  logic                   f_o;
  logic                   f_oe;
  logic [1:0]             st;
  int                     errors       = 0;
  int                     total_checks = 0;
  int                     hi;
  int                     hi_a;

  // clock, 25 ns period
  always #12.5 ref_clk = ~ref_clk;

  lcfec_switch_model sw_u (.pulse_mode(pm), .press(press), .pin(pins));

  lcfec_top #(.DEBOUNCE(4), .PWM_PERIOD(256)) dut_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .main_enable_a(pins[0]), .main_enable_b(pins[1]),
    .backlight_enable(bl), .pulse_mode(pm), .int_pwm_mode(ipm), .cmd_valid(cv), .cmd_on(con),
    .fade_up_time_set(fup), .fade_down_time_set(fdn), .fault_in(flt), .main_output_a(out_a),
    .main_output_b(out_b), .main_pwm_a(pwm_a), .main_pwm_b(pwm_b), .backlight_output(bl_o),
    .fault_flag_n_o(f_o), .fault_flag_n_oe(f_oe), .chan_on_state(st), .fault_flags(fflags)
  );

  // ==========================================
  // helpers
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle serial command
  task send(input int ch, input logic on);
    cv[ch]  = 1'b1;
    con[ch] = on;
    tick(1);
    cv = 2'h0;
  endtask

  task give_verdict;
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // watchdog
  initial
  begin
    #(25 * 8000);
    errors++;
    give_verdict();
  end

  // ==========================================
  // test sequence
  initial
  begin
    tick(3);
    reset_n = 1'b1;
    tick(2);
    check(out_a, 8'h00);
    check(f_oe, 1'b1);
    // each fault alone pulls the flag pin and shows its own bit
    for (int i = 0; i < 3; i++)
    begin
      flt = 3'(1 << i);
      tick(6);
      check(f_oe, 1'b0);
      check(f_o, 1'b0);
      check(fflags, 8'(flt));
      flt = '0;
      tick(6);
      check(f_oe, 1'b1);
    end
    // backlight: glitch ignored, levels followed
    bl = 1'b1;
    tick(100);
    check(bl_o, 1'b1);
    bl = 1'b0;
    tick(10);
    bl = 1'b1;
    tick(3);
    check(bl_o, 1'b1);
    bl = 1'b0;
    tick(100);
    check(bl_o, 1'b0);
    // pulse mode: long press gives one toggle, second press toggles back
    press[0] = 1'b1;
    tick(40);
    check(st[0], 1'b1);
    press[0] = 1'b0;
    tick(20);
    check(st[0], 1'b1);
    press[0] = 1'b1;
    tick(20);
    press[0] = 1'b0;
    tick(20);
    check(st[0], 1'b0);
    // level mode, then serial override
    pm = 1'b0;
    tick(20);
    press[1] = 1'b1;
    tick(20);
    check(st[1], 1'b1);
    send(1, 1'b0);
    tick(3);
    check(st[1], 1'b0);
    press[1] = 1'b0;
    tick(20);
    check(st[1], 1'b0);
    // grounded fade settings switch at once
    send(0, 1'b1);
    tick(3);
    check(out_a, 8'hff);
    send(0, 1'b0);
    tick(3);
    check(out_a, 8'h00);
    // ramp up, interrupt it, ramp down, then a full ramp
    fup = 32'h2;
    fdn = 32'h3;
    send(0, 1'b1);
    tick(70);
    check(8'(out_a != 8'h00 && out_a != 8'hff), 8'h01);
    send(0, 1'b0);
    tick(4);
    v = out_a;
    tick(30);
    check(8'(out_a < v), 8'h01);
    tick(250);
    check(out_a, 8'h00);
    send(0, 1'b1);
    tick(63 * 2 + 10);
    check(out_a, 8'hff);
    // internal pwm silent until commanded, then duty follows the level
    fup = 32'h0;
    ipm = 1'b1;
    tick(300);
    check(pwm_b, 1'b0);
    send(1, 1'b1);
    tick(300);
    check(out_b, 8'hff);
    hi = 0;
    hi_a = 0;
    repeat (256)
    begin
      tick(1);
      hi += int'(pwm_b);
      hi_a += int'(pwm_a);
    end
    check(8'(hi), 8'hff);
    check(8'(hi_a), 8'hff);
    give_verdict();
  end
endmodule
